/* shared/ddl_regs.svh */
`ifndef DDL_REGS_SVH
`define DDL_REGS_SVH

// Byte addresses on the register bus
`define DDL_ADDR_CTRL 12'h000
`define DDL_ADDR_STATUS 12'h004
`define DDL_ADDR_LATCH_A 12'h008
`define DDL_ADDR_LATCH_B 12'h00c
`define DDL_ADDR_INPUT_A 12'h010
`define DDL_ADDR_INPUT_B 12'h014

// Control fields
`define DDL_CTRL_BIPOLAR 0
`define DDL_CTRL_HOLD 1
`define DDL_CTRL_RESET 2'h0

// Status fields
`define DDL_STAT_ACTIVE 0
`define DDL_STAT_PENDING 1
`define DDL_STAT_FORMAT 2
`define DDL_STAT_FULL 3
`define DDL_STAT_LEVEL_LSB 4

// Serial word layout
`define DDL_WORD_BITS 16
`define DDL_LAST_BIT 4'hf
`define DDL_CHAN_BIT 12
`define DDL_MSB_FLIP 12'h800
`define DDL_FIFO_DEPTH 8

// Pin levels while the link is idle: sclk, serial_data_in, sync_n, latch_load_strobe_n_n, clear_n, format
`define DDL_PINS_IDLE 6'h2e

`endif

/* shared/ddl_pkg.sv */
`default_nettype none

package ddl_pkg;

  typedef struct packed {
    logic auto_load;
    logic chan;
    logic [11:0] data;
  } ddl_word_type;

  typedef struct packed {
    logic sclk;
    logic serial_data_in;
    logic sync_n;
    logic latch_load_strobe_n_n;
    logic clear_n;
    logic fmt;
  } ddl_pins_type;

  typedef enum logic {
    LINK_IDLE,
    LINK_SHIFT
  } ddl_link_state_type;

endpackage

`default_nettype wire

/* rtl/ddl_loader.sv */
// Implementation choices: the address map and register access over APB.
`timescale 1ns/1ps
`include "ddl_regs.svh"
`default_nettype none

module ddl_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Fill level
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = count != (AW + 1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data = mem[rd_ptr];
  assign level = count;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage carries no reset; only valid entries are ever read
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

module ddl_loader (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Serial link pins
  input wire logic SCLK,
  input wire logic SERIAL_DATA_IN,
  input wire logic FRAME_SYNC_N,
  input wire logic LATCH_LOAD_STROBE_N,
  input wire logic CLEAR_N,
  input wire logic FORMAT_SELECT,
  // Converter codes
  output logic [11:0] CODE_A,
  output logic [11:0] CODE_B
);
  ddl_pkg::ddl_pins_type pins_in;
  ddl_pkg::ddl_pins_type pins_meta;
  ddl_pkg::ddl_pins_type pins_sync;
  ddl_pkg::ddl_pins_type pins_prev;
  ddl_pkg::ddl_link_state_type state;
  ddl_pkg::ddl_word_type pend;
  ddl_pkg::ddl_word_type fifo_out;
  logic [14:0] shift;
  logic [15:0] full_word;
  logic [3:0] bit_cnt;
  logic frame_auto;
  logic pend_valid;
  logic fifo_ready;
  logic fifo_valid;
  logic drain_ready;
  logic [$clog2(`DDL_FIFO_DEPTH):0] fifo_level;
  logic [11:0] latch_a;
  logic [11:0] latch_b;
  logic [11:0] input_a;
  logic [11:0] input_b;
  logic [1:0] ctrl;
  logic clear;
  logic sclk_fall;
  logic sync_fall;
  logic sync_rise;
  logic latch_load_strobe_n_fall;
  logic frame_start;
  logic word_done;
  logic twos;
  logic pop;
  logic setup;
  logic access;
  logic mapped;
  logic [31:0] next_rdata;
  logic [31:0] status;

  assign pins_in = '{sclk: SCLK, serial_data_in: SERIAL_DATA_IN, sync_n: FRAME_SYNC_N,
                     latch_load_strobe_n_n: LATCH_LOAD_STROBE_N, clear_n: CLEAR_N, fmt: FORMAT_SELECT};

  // Two stages before any logic; a third only for edge detection
  always_ff @(posedge CLK) begin
    if (RST) begin
      pins_meta <= `DDL_PINS_IDLE;
      pins_sync <= `DDL_PINS_IDLE;
      pins_prev <= `DDL_PINS_IDLE;
    end else begin
      pins_meta <= pins_in;
      pins_sync <= pins_meta;
      pins_prev <= pins_sync;
    end
  end

  assign clear = !pins_sync.clear_n;
  assign sclk_fall = pins_prev.sclk && !pins_sync.sclk;
  assign sync_fall = pins_prev.sync_n && !pins_sync.sync_n;
  assign sync_rise = !pins_prev.sync_n && pins_sync.sync_n;
  assign latch_load_strobe_n_fall = pins_prev.latch_load_strobe_n_n && !pins_sync.latch_load_strobe_n_n;
  // A word still waiting for buffer space holds off the next frame
  assign frame_start = sync_fall && !pend_valid;
  assign full_word = {shift, pins_sync.serial_data_in};
  assign word_done = state == ddl_pkg::LINK_SHIFT && sclk_fall && !pins_sync.sync_n
                     && bit_cnt == `DDL_LAST_BIT;

  // Frame tracking and bit counting
  always_ff @(posedge CLK) begin
    if (RST || clear) begin
      state <= ddl_pkg::LINK_IDLE;
      bit_cnt <= '0;
      frame_auto <= 1'b0;
    end else begin
      unique case (state)
        ddl_pkg::LINK_IDLE: begin
          if (frame_start) begin
            state <= ddl_pkg::LINK_SHIFT;
            bit_cnt <= '0;
            frame_auto <= !pins_sync.latch_load_strobe_n_n;
          end
        end
        ddl_pkg::LINK_SHIFT: begin
          if (sync_rise) begin
            state <= ddl_pkg::LINK_IDLE;
          end else if (word_done) begin
            state <= ddl_pkg::LINK_IDLE;
          end else if (sclk_fall) begin
            bit_cnt <= bit_cnt + 1'b1;
          end
        end
      endcase
    end
  end

  // Shift register takes bits only inside the sixteen-edge window
  always_ff @(posedge CLK) begin
    if (RST || clear) begin
      shift <= '0;
    end else if (state == ddl_pkg::LINK_SHIFT && sclk_fall && !sync_rise) begin
      shift <= full_word[14:0];
    end
  end

  // Completed word waits here until the buffer accepts it
  always_ff @(posedge CLK) begin
    if (RST || clear) begin
      pend_valid <= 1'b0;
      pend <= '0;
    end else if (word_done && !sync_rise) begin
      pend_valid <= 1'b1;
      pend <= '{auto_load: frame_auto, chan: full_word[`DDL_CHAN_BIT],
                data: full_word[11:0]};
    end else if (fifo_ready) begin
      pend_valid <= 1'b0;
    end
  end

  ddl_fifo #(
    .WIDTH($bits(ddl_pkg::ddl_word_type)),
    .DEPTH(`DDL_FIFO_DEPTH)
  ) u_fifo (
    .clk(CLK),
    .rst(RST),
    .flush(clear),
    .in_valid(pend_valid),
    .in_ready(fifo_ready),
    .in_data(pend),
    .out_valid(fifo_valid),
    .out_ready(drain_ready),
    .out_data(fifo_out),
    .level(fifo_level)
  );

  // Strobe edge has priority over the drain, so the two never collide
  assign drain_ready = !ctrl[`DDL_CTRL_HOLD] && !latch_load_strobe_n_fall && !clear;
  assign pop = fifo_valid && drain_ready;

  // Input registers and channel latches
  always_ff @(posedge CLK) begin
    if (RST || clear) begin
      latch_a <= '0;
      latch_b <= '0;
      input_a <= '0;
      input_b <= '0;
    end else if (latch_load_strobe_n_fall) begin
      latch_a <= input_a;
      latch_b <= input_b;
    end else if (pop) begin
      if (fifo_out.chan) begin
        input_b <= fifo_out.data;
        if (fifo_out.auto_load) begin
          latch_b <= fifo_out.data;
        end
      end else begin
        input_a <= fifo_out.data;
        if (fifo_out.auto_load) begin
          latch_a <= fifo_out.data;
        end
      end
    end
  end

  // Only twos complement needs the MSB flipped; offset binary is the native code
  assign twos = ctrl[`DDL_CTRL_BIPOLAR] && pins_sync.fmt;

  always_ff @(posedge CLK) begin
    if (RST) begin
      CODE_A <= '0;
      CODE_B <= '0;
    end else if (twos) begin
      CODE_A <= latch_a ^ `DDL_MSB_FLIP;
      CODE_B <= latch_b ^ `DDL_MSB_FLIP;
    end else begin
      CODE_A <= latch_a;
      CODE_B <= latch_b;
    end
  end

  // Register bus, zero wait states
  assign setup = PSEL && !PENABLE;
  assign access = PSEL && PENABLE;
  assign PREADY = access;

  assign status = {24'h0, fifo_level, !fifo_ready, pins_sync.fmt, pend_valid,
                   state == ddl_pkg::LINK_SHIFT};

  always_comb begin
    mapped = 1'b1;
    next_rdata = '0;
    unique case (PADDR)
      `DDL_ADDR_CTRL: next_rdata = {30'h0, ctrl};
      `DDL_ADDR_STATUS: next_rdata = status;
      `DDL_ADDR_LATCH_A: next_rdata = {20'h0, latch_a};
      `DDL_ADDR_LATCH_B: next_rdata = {20'h0, latch_b};
      `DDL_ADDR_INPUT_A: next_rdata = {20'h0, input_a};
      `DDL_ADDR_INPUT_B: next_rdata = {20'h0, input_b};
      default: mapped = 1'b0;
    endcase
  end

  // Read data and error are captured in setup, held through access
  always_ff @(posedge CLK) begin
    if (RST) begin
      PRDATA <= '0;
      PSLVERR <= 1'b0;
    end else if (setup) begin
      PRDATA <= PWRITE ? 32'h0 : next_rdata;
      PSLVERR <= !mapped || (PWRITE && PADDR != `DDL_ADDR_CTRL);
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      ctrl <= `DDL_CTRL_RESET;
    end else if (access && PWRITE && PADDR == `DDL_ADDR_CTRL) begin
      ctrl <= PWDATA[1:0];
    end
  end

  a_frame_start_count: assert property (
    @(posedge CLK) disable iff (RST)
    (state == ddl_pkg::LINK_IDLE && frame_start && !clear)
      |=> (state == ddl_pkg::LINK_SHIFT && bit_cnt == 4'h0))
    else $error("frame start did not arm the bit counter");

  a_sixteen_bits_done: assert property (
    @(posedge CLK) disable iff (RST)
    (word_done && !sync_rise && !clear)
      |=> (pend_valid && state == ddl_pkg::LINK_IDLE && pend.data == $past(full_word[11:0])))
    else $error("sixteenth edge did not complete the word");

  a_extra_edges_ignored: assert property (
    @(posedge CLK) disable iff (RST)
    (state == ddl_pkg::LINK_IDLE && !clear) |=> $stable(shift))
    else $error("shift register moved outside a frame");

  a_partial_discard: assert property (
    @(posedge CLK) disable iff (RST)
    (state == ddl_pkg::LINK_SHIFT && sync_rise && !pend_valid)
      |=> (state == ddl_pkg::LINK_IDLE && !pend_valid))
    else $error("partial word was kept");

  a_clear_empties: assert property (
    @(posedge CLK) disable iff (RST)
    clear |=> (latch_a == 12'h0 && latch_b == 12'h0 && shift == 15'h0 && !pend_valid))
    else $error("clear left data behind");

  a_strobe_loads_both: assert property (
    @(posedge CLK) disable iff (RST)
    (latch_load_strobe_n_fall && !clear) |=> (latch_a == $past(input_a) && latch_b == $past(input_b)))
    else $error("strobe edge did not load both latches");

  a_auto_load_route: assert property (
    @(posedge CLK) disable iff (RST)
    (pop && !latch_load_strobe_n_fall && fifo_out.auto_load && !fifo_out.chan)
      |=> (latch_a == $past(fifo_out.data) && $stable(latch_b)))
    else $error("automatic load went to the wrong latch");

  a_deferred_holds: assert property (
    @(posedge CLK) disable iff (RST)
    (pop && !fifo_out.auto_load && fifo_out.chan)
      |=> (input_b == $past(fifo_out.data) && $stable(latch_a) && $stable(latch_b)))
    else $error("deferred word changed a latch");

  a_code_twos: assert property (
    @(posedge CLK) disable iff (RST)
    twos |=> (CODE_A == ($past(latch_a) ^ 12'h800)))
    else $error("twos complement code not offset by mid-scale");

  a_code_natural: assert property (
    @(posedge CLK) disable iff (RST)
    (!ctrl[`DDL_CTRL_BIPOLAR]) |=> (CODE_B == $past(latch_b)))
    else $error("unipolar code altered");

  a_code_offset: assert property (
    @(posedge CLK) disable iff (RST)
    (ctrl[`DDL_CTRL_BIPOLAR] && !pins_sync.fmt) |=> (CODE_A == $past(latch_a)))
    else $error("offset binary code altered");
endmodule

`default_nettype wire

/* tb/ddl_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module ddl_host_model (
  // Serial link
  output logic sclk,
  output logic serial_data_in,
  output logic sync_n,
  output logic latch_load_strobe_n_n
);
  initial begin
    sclk = 1'b1;
    serial_data_in = 1'b0;
    sync_n = 1'b1;
    latch_load_strobe_n_n = 1'b1;
  end

  // Bits change on the rising clock, so each one is stable well around the fall
  // Pins move off the system clock edge, except the strobe drop at the start of a send that directly follows another, which lands on a rising edge
  task automatic send(input logic [15:0] w, input int nbits, input logic hold);
    #3 latch_load_strobe_n_n = hold;
    #34 sync_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      serial_data_in = w[15 - (i % 16)];
      #80 sclk = 1'b0;
      #80 sclk = 1'b1;
    end
    #80 sync_n = 1'b1;
    serial_data_in = ~serial_data_in;
    latch_load_strobe_n_n = 1'b1;
    #200;
  endtask

  task automatic strobe();
    #30 latch_load_strobe_n_n = 1'b0;
    #200 latch_load_strobe_n_n = 1'b1;
  endtask
endmodule

`default_nettype wire

/* tb/test_dual_dac_serial_word_loader.sv */
`timescale 1ns/1ps
`include "ddl_regs.svh"
`default_nettype none

module test_dual_dac_serial_word_loader;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic clear_n = 1'b1;
  logic format_select = 1'b0;
  logic [11:0] code_a;
  logic [11:0] code_b;
  logic [11:0] la = 12'h000;
  logic [11:0] lb = 12'h000;
  logic [11:0] d;
  logic ch;
  wire sclk;
  wire serial_data_in;
  wire sync_n;
  wire latch_load_strobe_n_n;
  int err_total = 0;
  int checked = 0;

  always #10 clk = ~clk;

  ddl_host_model u_host (.sclk(sclk), .serial_data_in(serial_data_in), .sync_n(sync_n), .latch_load_strobe_n_n(latch_load_strobe_n_n));

  ddl_loader u_dut (
    .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SCLK(sclk), .SERIAL_DATA_IN(serial_data_in), .FRAME_SYNC_N(sync_n),
    .LATCH_LOAD_STROBE_N(latch_load_strobe_n_n), .CLEAR_N(clear_n), .FORMAT_SELECT(format_select),
    .CODE_A(code_a), .CODE_B(code_b)
  );

  function automatic logic [11:0] exp_code(logic [11:0] v, logic bip, logic fmt);
    return (bip && fmt) ? v ^ 12'h800 : v;
  endfunction

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      err_total++;
    end
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v,
                     input logic [31:0] e, input logic ee);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    if (!w) chk("prdata", e, prdata);
    chk("pslverr", {31'h0, ee}, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_code(input logic c, input logic [11:0] e);
    for (int i = 0; i < 60 && (c ? code_b : code_a) !== e; i++) @(posedge clk);
    chk("code", {20'h0, e}, {20'h0, c ? code_b : code_a});
  endtask

  task automatic end_sim();
    if (err_total == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #1_500_000;
    err_total++;
    end_sim();
  end

  initial begin
    void'($urandom(32'hdb45));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(0, `DDL_ADDR_CTRL, 0, 32'h0, 0);
    apb(0, 12'h018, 0, 32'h0, 1);
    apb(1, `DDL_ADDR_STATUS, 32'h1, 0, 1);
    chk("code_a", 32'h0, {20'h0, code_a});
    for (int i = 0; i < 6; i++) begin
      d = 12'($urandom);
      ch = 1'($urandom);
      u_host.send({3'($urandom), ch, d}, (i == 5) ? 20 : 16, 0);
      wait_code(ch, d);
      apb(0, ch ? `DDL_ADDR_LATCH_B : `DDL_ADDR_LATCH_A, 0, {20'h0, d}, 0);
      if (ch) lb = d;
      else la = d;
    end
    // Early frame end, then two deferred words released by one strobe
    u_host.send({4'h0, ~la}, 10, 0);
    repeat (30) @(posedge clk);
    chk("code_a", {20'h0, la}, {20'h0, code_a});
    d = la;
    la = 12'($urandom);
    lb = 12'h800;
    u_host.send({4'h0, la}, 16, 1);
    u_host.send({4'h1, lb}, 16, 1);
    repeat (30) @(posedge clk);
    chk("code_a", {20'h0, d}, {20'h0, code_a});
    chk("code_b", 32'h0, {31'h0, code_b == lb});
    u_host.strobe();
    wait_code(0, la);
    wait_code(1, lb);
    apb(1, `DDL_ADDR_CTRL, 32'h1, 0, 0);
    for (int k = 0; k < 3; k++) begin
      d = (k == 0) ? 12'h7ff : (k == 1) ? 12'h800 : 12'($urandom);
      format_select <= 1'b1;
      u_host.send({4'h0, d}, 16, 0);
      wait_code(0, exp_code(d, 1, 1));
      format_select <= 1'b0;
      wait_code(0, exp_code(d, 1, 0));
    end
    // Drain held: eight words fill the buffer, the ninth waits
    apb(1, `DDL_ADDR_CTRL, 32'h2, 0, 0);
    for (int i = 0; i < 9; i++) begin
      d = 12'($urandom);
      u_host.send({4'h0, d}, 16, 0);
    end
    apb(0, `DDL_ADDR_STATUS, 0, 32'h8a, 0);
    apb(1, `DDL_ADDR_CTRL, 32'h0, 0, 0);
    wait_code(0, d);
    clear_n <= 1'b0;
    repeat (5) @(posedge clk);
    clear_n <= 1'b1;
    wait_code(0, 12'h0);
    wait_code(1, 12'h0);
    apb(0, `DDL_ADDR_INPUT_B, 0, 32'h0, 0);
    end_sim();
  end
endmodule

`default_nettype wire
